// ---- src/i2c_port_status.sv ----
// status register of a two-wire serial port, avalon-mm register slave
// assumes scl and sda pins are asynchronous and sampled on clock
//
// The Avalon-MM slave port and the register offsets are this design's own decisions.
module i2c_port_status (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [4:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic             waitrequest,
  output logic [31:0]      readdata,
  input  wire logic        scl_pin,
  input  wire logic        sda_pin,
  output logic             irq,
  output logic             slew_control_off,
  output logic             bus_level_select,
  output logic             master_active
);

  localparam int IRQ_W_L = i2c_status_pkg::IRQ_W;   // event count

  logic        scl_s, sda_s;                 // synchronised pins
  logic        start_p, stop_p;              // bus condition pulses
  logic        scl_rise_p, scl_fall_p;       // scl edge pulses
  logic        slew_q, slew_d;               // slew control off
  logic        cke_q, cke_d;                 // smbus level select
  logic        dna_q, dna_d;                 // last byte was data
  logic        stop_q, stop_d;               // stop seen last
  logic        start_q, start_d;             // start seen last
  logic        dir_q, dir_d;                 // matched direction
  logic        upd_q, upd_d;                 // address update request
  logic        full_q, full_d;               // buffer holds a byte
  logic        busy_q, busy_d;               // master transmit busy
  logic        tenm_q, tenm_d;               // full ten-bit match held
  logic [7:0]  ctrl_q, ctrl_d;               // control register
  logic [9:0]  own_q, own_d;                 // own slave address
  logic [7:0]  rx_q, rx_d;                   // received byte
  logic [7:0]  tx_q, tx_d;                   // byte to transmit
  logic [7:0]  shift_q, shift_d;             // bus shift register
  logic [3:0]  cnt_q, cnt_d;                 // bit count in byte
  logic [IRQ_W_L-1:0] ist_q, ist_d;          // sticky events
  logic [IRQ_W_L-1:0] mask_q, mask_d;        // event mask
  logic        irq_q, irq_d;                 // interrupt line
  logic        act_q, act_d;                 // master active flag
  logic        wait_q, wait_d;               // avalon waitrequest
  logic [31:0] rdata_q, rdata_d;             // avalon read data
  logic        accept;                       // request completes now
  logic        wr, rd;                       // completing write/read
  logic [31:0] wmask;                        // byte lanes as bits
  logic [IRQ_W_L-1:0] ev;                    // events this cycle
  logic [IRQ_W_L-1:0] clr;                   // w1c clear bits
  logic [7:0]  status_v;                     // status low byte
  logic        master;                       // master role selected
  i2c_status_pkg::link_state_e state_q, state_d;

  // pins cross into the clock domain here
  i2c_sync #(
    .WIDTH     (2),
    .RESET_VAL (1'b1)
  ) u_sync (
    .clock (clock),
    .rst   (rst),
    .d     ({scl_pin, sda_pin}),
    .q     ({scl_s, sda_s})
  );

  // start, stop and scl edge detection
  i2c_cond_detect u_cond (
    .clock      (clock),
    .rst        (rst),
    .scl_s      (scl_s),
    .sda_s      (sda_s),
    .start_p    (start_p),
    .stop_p     (stop_p),
    .scl_rise_p (scl_rise_p),
    .scl_fall_p (scl_fall_p)
  );

  assign master = ctrl_q[i2c_status_pkg::CT_MASTER_BIT];
  assign accept = (read || write) && !wait_q;
  assign wr     = write && accept;
  assign rd     = read && accept;
  assign wmask  = {{8{byteenable[3]}}, {8{byteenable[2]}},
                   {8{byteenable[1]}}, {8{byteenable[0]}}};

  // status byte as software sees it
  always_comb begin
    status_v = i2c_status_pkg::STATUS_RST;
    status_v[i2c_status_pkg::ST_SLEW_BIT] = slew_q;
    status_v[i2c_status_pkg::ST_CKE_BIT]  = cke_q;
    status_v[i2c_status_pkg::ST_DNA_BIT]  = master ? 1'b0 : dna_q;
    status_v[i2c_status_pkg::ST_STOP_BIT] = stop_q;
    status_v[i2c_status_pkg::ST_STRT_BIT] = start_q;
    status_v[i2c_status_pkg::ST_RW_BIT]   = master ? busy_q : dir_q;
    status_v[i2c_status_pkg::ST_UPD_BIT]  = upd_q;
    status_v[i2c_status_pkg::ST_FULL_BIT] = full_q;
  end

  // bus slave: one wait cycle, then a one-cycle answer
  always_comb begin
    wait_d  = !((read || write) && wait_q);
    rdata_d = rdata_q;
    if (read && wait_q) begin
      case (address)
        i2c_status_pkg::OFF_STATUS:     rdata_d = {24'h00_0000, status_v};
        i2c_status_pkg::OFF_CONTROL:    rdata_d = {24'h00_0000, ctrl_q};
        i2c_status_pkg::OFF_OWN_ADDR:   rdata_d = {22'h00_0000, own_q};
        i2c_status_pkg::OFF_DATA:       rdata_d = {24'h00_0000, rx_q};
        i2c_status_pkg::OFF_IRQ_STATUS: rdata_d = {28'h000_0000, ist_q};
        i2c_status_pkg::OFF_IRQ_MASK:   rdata_d = {28'h000_0000, mask_q};
        i2c_status_pkg::OFF_ACTIVITY:   rdata_d = {31'h0000_0000, act_q};
        default:                        rdata_d = 32'h0000_0000;
      endcase
    end
  end

  // core: software effects first, bus events after so a bus event wins
  always_comb begin
    slew_d  = slew_q;
    cke_d   = cke_q;
    dna_d   = dna_q;
    stop_d  = stop_q;
    start_d = start_q;
    dir_d   = dir_q;
    upd_d   = upd_q;
    full_d  = full_q;
    busy_d  = busy_q;
    tenm_d  = tenm_q;
    ctrl_d  = ctrl_q;
    own_d   = own_q;
    rx_d    = rx_q;
    tx_d    = tx_q;
    shift_d = shift_q;
    cnt_d   = cnt_q;
    state_d = state_q;
    mask_d  = mask_q;
    ev      = '0;
    clr     = '0;
    // register writes honour byte lanes
    if (wr) begin
      case (address)
        i2c_status_pkg::OFF_STATUS: begin
          // only the two selection bits take a write
          if (wmask[i2c_status_pkg::ST_SLEW_BIT]) begin
            slew_d = writedata[i2c_status_pkg::ST_SLEW_BIT];
          end
          if (wmask[i2c_status_pkg::ST_CKE_BIT]) begin
            cke_d = writedata[i2c_status_pkg::ST_CKE_BIT];
          end
        end
        i2c_status_pkg::OFF_CONTROL: begin
          ctrl_d = (ctrl_q & ~wmask[7:0]) | (writedata[7:0] & wmask[7:0]);
        end
        i2c_status_pkg::OFF_OWN_ADDR: begin
          own_d = (own_q & ~wmask[9:0]) | (writedata[9:0] & wmask[9:0]);
          upd_d = 1'b0;
        end
        i2c_status_pkg::OFF_DATA: begin
          if (byteenable[0]) begin
            tx_d = writedata[7:0];
            full_d = 1'b1;
            if (master) begin
              busy_d = 1'b1;
            end
          end
        end
        i2c_status_pkg::OFF_IRQ_STATUS: begin
          clr = writedata[IRQ_W_L-1:0] & wmask[IRQ_W_L-1:0];
        end
        i2c_status_pkg::OFF_IRQ_MASK: begin
          mask_d = (mask_q & ~wmask[IRQ_W_L-1:0])
                 | (writedata[IRQ_W_L-1:0] & wmask[IRQ_W_L-1:0]);
        end
        default: begin
          // unmapped or read-only: write ignored
        end
      endcase
    end
    // reading a received byte empties the buffer
    if (rd && (address == i2c_status_pkg::OFF_DATA)
        && !(master ? busy_q : dir_q)) begin
      full_d = 1'b0;
    end
    if (!ctrl_q[i2c_status_pkg::CT_ON_BIT]) begin
      // module off: conditions forgotten, tracker parked
      start_d = 1'b0;
      stop_d  = 1'b0;
      busy_d  = 1'b0;
      tenm_d  = 1'b0;
      cnt_d   = 4'h0;
      state_d = i2c_status_pkg::ST_IDLE;
    end else if (start_p) begin
      // start or repeated start opens an address byte
      start_d = 1'b1;
      stop_d  = 1'b0;
      cnt_d   = 4'h0;
      state_d = i2c_status_pkg::ST_ADDR;
      ctrl_d[i2c_status_pkg::CT_BEGIN_BIT]  = 1'b0;
      ctrl_d[i2c_status_pkg::CT_REPEAT_BIT] = 1'b0;
      ev[i2c_status_pkg::IRQ_START_BIT] = 1'b1;
    end else if (stop_p) begin
      // stop closes the transfer
      stop_d  = 1'b1;
      start_d = 1'b0;
      busy_d  = 1'b0;
      tenm_d  = 1'b0;
      cnt_d   = 4'h0;
      state_d = i2c_status_pkg::ST_IDLE;
      ctrl_d[i2c_status_pkg::CT_HALT_BIT] = 1'b0;
      ev[i2c_status_pkg::IRQ_STOP_BIT] = 1'b1;
    end else if (scl_rise_p && (state_q != i2c_status_pkg::ST_IDLE)) begin
      if (cnt_q != i2c_status_pkg::BYTE_BITS) begin
        // shift one data bit, msb first
        shift_d = {shift_q[6:0], sda_s};
        cnt_d   = cnt_q + 4'h1;
      end else begin
        // ninth clock: byte complete
        cnt_d = 4'h0;
        ev[i2c_status_pkg::IRQ_BYTE_BIT] = 1'b1;
        if (master) begin
          if (ctrl_q[i2c_status_pkg::CT_RECV_BIT]) begin
            rx_d = shift_q;
            full_d = 1'b1;
            ctrl_d[i2c_status_pkg::CT_RECV_BIT] = 1'b0;
          end else if (busy_q) begin
            busy_d = 1'b0;
            full_d = 1'b0;
          end
        end else begin
          case (state_q)
            i2c_status_pkg::ST_ADDR: begin
              if (ctrl_q[i2c_status_pkg::CT_TEN_BIT]) begin
                // high address byte of a ten-bit address
                if ((shift_q[7:3] == i2c_status_pkg::TEN_BIT_PREFIX)
                    && (shift_q[2:1] == own_q[9:8])) begin
                  dna_d = 1'b0;
                  upd_d = 1'b1;
                  dir_d = shift_q[0];
                  if (shift_q[0] && tenm_q) begin
                    state_d = i2c_status_pkg::ST_DATA;
                    ev[i2c_status_pkg::IRQ_MATCH_BIT] = 1'b1;
                  end else if (!shift_q[0]) begin
                    state_d = i2c_status_pkg::ST_ADDR_LOW;
                  end else begin
                    state_d = i2c_status_pkg::ST_IGNORE;
                  end
                end else begin
                  state_d = i2c_status_pkg::ST_IGNORE;
                end
              end else if (shift_q[7:1] == own_q[6:0]) begin
                dna_d   = 1'b0;
                dir_d   = shift_q[0];
                state_d = i2c_status_pkg::ST_DATA;
                ev[i2c_status_pkg::IRQ_MATCH_BIT] = 1'b1;
              end else begin
                state_d = i2c_status_pkg::ST_IGNORE;
              end
            end
            i2c_status_pkg::ST_ADDR_LOW: begin
              // low address byte completes a ten-bit match
              if (shift_q == own_q[7:0]) begin
                dna_d   = 1'b0;
                upd_d   = 1'b1;
                tenm_d  = 1'b1;
                state_d = i2c_status_pkg::ST_DATA;
                ev[i2c_status_pkg::IRQ_MATCH_BIT] = 1'b1;
              end else begin
                tenm_d  = 1'b0;
                state_d = i2c_status_pkg::ST_IGNORE;
              end
            end
            i2c_status_pkg::ST_DATA: begin
              dna_d = 1'b1;
              if (dir_q) begin
                full_d = 1'b0;
              end else begin
                rx_d = shift_q;
                full_d = 1'b1;
              end
            end
            default: begin
              // not addressed: bytes pass by
            end
          endcase
        end
      end
    end else if (scl_fall_p) begin
      // acknowledge sequence ends on the next falling clock
      ctrl_d[i2c_status_pkg::CT_ACK_BIT] = 1'b0;
    end
    ist_d = (ist_q & ~clr) | ev;
    irq_d = |(ist_q & mask_q);
    act_d = busy_q | ctrl_q[i2c_status_pkg::CT_BEGIN_BIT]
          | ctrl_q[i2c_status_pkg::CT_REPEAT_BIT]
          | ctrl_q[i2c_status_pkg::CT_HALT_BIT]
          | ctrl_q[i2c_status_pkg::CT_RECV_BIT]
          | ctrl_q[i2c_status_pkg::CT_ACK_BIT];
  end

  // registers, all zero after reset except waitrequest
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      slew_q  <= 1'b0;
      cke_q   <= 1'b0;
      dna_q   <= 1'b0;
      stop_q  <= 1'b0;
      start_q <= 1'b0;
      dir_q   <= 1'b0;
      upd_q   <= 1'b0;
      full_q  <= 1'b0;
      busy_q  <= 1'b0;
      tenm_q  <= 1'b0;
      ctrl_q  <= i2c_status_pkg::CONTROL_RST;
      own_q   <= i2c_status_pkg::OWN_RST;
      rx_q    <= 8'h00;
      tx_q    <= 8'h00;
      shift_q <= 8'h00;
      cnt_q   <= 4'h0;
      state_q <= i2c_status_pkg::ST_IDLE;
      ist_q   <= '0;
      mask_q  <= i2c_status_pkg::MASK_RST;
      irq_q   <= 1'b0;
      act_q   <= 1'b0;
      wait_q  <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else begin
      slew_q  <= slew_d;
      cke_q   <= cke_d;
      dna_q   <= dna_d;
      stop_q  <= stop_d;
      start_q <= start_d;
      dir_q   <= dir_d;
      upd_q   <= upd_d;
      full_q  <= full_d;
      busy_q  <= busy_d;
      tenm_q  <= tenm_d;
      ctrl_q  <= ctrl_d;
      own_q   <= own_d;
      rx_q    <= rx_d;
      tx_q    <= tx_d;
      shift_q <= shift_d;
      cnt_q   <= cnt_d;
      state_q <= state_d;
      ist_q   <= ist_d;
      mask_q  <= mask_d;
      irq_q   <= irq_d;
      act_q   <= act_d;
      wait_q  <= wait_d;
      rdata_q <= rdata_d;
    end
  end

  assign waitrequest      = wait_q;
  assign readdata         = rdata_q;
  assign irq              = irq_q;
  assign slew_control_off = slew_q;  // to pad slew control
  assign bus_level_select = cke_q;   // to pad input thresholds
  assign master_active    = act_q;

endmodule // i2c_port_status

// ---- pkg/i2c_status_pkg.sv ----
// constants shared by the two-wire port status logic and its helpers
// assumes a 32-bit avalon-mm slave with byte addresses on a 5-bit bus
package i2c_status_pkg;

  // register byte offsets, one aligned word each
  localparam logic [4:0] OFF_STATUS     = 5'h00;
  localparam logic [4:0] OFF_CONTROL    = 5'h04;
  localparam logic [4:0] OFF_OWN_ADDR   = 5'h08;
  localparam logic [4:0] OFF_DATA       = 5'h0C;
  localparam logic [4:0] OFF_IRQ_STATUS = 5'h10;
  localparam logic [4:0] OFF_IRQ_MASK   = 5'h14;
  localparam logic [4:0] OFF_ACTIVITY   = 5'h18;

  // status field positions
  localparam int ST_SLEW_BIT = 7;
  localparam int ST_CKE_BIT  = 6;
  localparam int ST_DNA_BIT  = 5;
  localparam int ST_STOP_BIT = 4;
  localparam int ST_STRT_BIT = 3;
  localparam int ST_RW_BIT   = 2;
  localparam int ST_UPD_BIT  = 1;
  localparam int ST_FULL_BIT = 0;

  // control field positions
  localparam int CT_ON_BIT     = 0;
  localparam int CT_MASTER_BIT = 1;
  localparam int CT_TEN_BIT    = 2;
  localparam int CT_BEGIN_BIT  = 3;
  localparam int CT_REPEAT_BIT = 4;
  localparam int CT_HALT_BIT   = 5;
  localparam int CT_RECV_BIT   = 6;
  localparam int CT_ACK_BIT    = 7;

  // interrupt event positions
  localparam int IRQ_W         = 4;
  localparam int IRQ_START_BIT = 0;
  localparam int IRQ_STOP_BIT  = 1;
  localparam int IRQ_BYTE_BIT  = 2;
  localparam int IRQ_MATCH_BIT = 3;

  // reset values
  localparam logic [7:0]       STATUS_RST  = 8'h00;
  localparam logic [7:0]       CONTROL_RST = 8'h00;
  localparam logic [9:0]       OWN_RST     = 10'h000;
  localparam logic [IRQ_W-1:0] MASK_RST    = 4'h0;

  // bus framing
  localparam logic [3:0] BYTE_BITS      = 4'h8;
  localparam logic [4:0] TEN_BIT_PREFIX = 5'h1E;

  // byte tracker states
  typedef enum logic [2:0] {
    ST_IDLE     = 3'h0,
    ST_ADDR     = 3'h1,
    ST_ADDR_LOW = 3'h2,
    ST_DATA     = 3'h3,
    ST_IGNORE   = 3'h4
  } link_state_e;

endpackage

// ---- src/i2c_sync.sv ----
// two flip-flop synchroniser for asynchronous level inputs
// assumes inputs may change at any time relative to clock
module i2c_sync #(
  parameter int         WIDTH     = 1,
  parameter logic [0:0] RESET_VAL = 1'b1
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_q;   // first stage, read by second stage only
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] hold_q;   // second stage, safe to use
  logic [WIDTH-1:0] hold_d;

  // next values: plain shift through the two stages
  always_comb begin
    meta_d = d;
    hold_d = meta_q;
  end

  // registers, idle level on reset
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meta_q <= {WIDTH{RESET_VAL}};
      hold_q <= {WIDTH{RESET_VAL}};
    end else begin
      meta_q <= meta_d;
      hold_q <= hold_d;
    end
  end

  assign q = hold_q;

endmodule // i2c_sync

// ---- src/i2c_cond_detect.sv ----
// finds start, stop and clock edges on synchronised scl and sda
// assumes both inputs already passed a synchroniser on clock
module i2c_cond_detect (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic scl_s,
  input  wire logic sda_s,
  output logic      start_p,
  output logic      stop_p,
  output logic      scl_rise_p,
  output logic      scl_fall_p
);

  logic scl_prev_q, scl_prev_d;   // scl one cycle back
  logic sda_prev_q, sda_prev_d;   // sda one cycle back
  logic start_q, start_d;         // sda fell while scl high
  logic stop_q, stop_d;           // sda rose while scl high
  logic rise_q, rise_d;           // scl low to high
  logic fall_q, fall_d;           // scl high to low

  // edge and condition decode, one-cycle pulses
  always_comb begin
    scl_prev_d = scl_s;
    sda_prev_d = sda_s;
    start_d    = scl_s && scl_prev_q && sda_prev_q && !sda_s;
    stop_d     = scl_s && scl_prev_q && !sda_prev_q && sda_s;
    rise_d     = scl_s && !scl_prev_q;
    fall_d     = !scl_s && scl_prev_q;
  end

  // registers, idle bus is high on both wires
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
      start_q    <= 1'b0;
      stop_q     <= 1'b0;
      rise_q     <= 1'b0;
      fall_q     <= 1'b0;
    end else begin
      scl_prev_q <= scl_prev_d;
      sda_prev_q <= sda_prev_d;
      start_q    <= start_d;
      stop_q     <= stop_d;
      rise_q     <= rise_d;
      fall_q     <= fall_d;
    end
  end

  assign start_p    = start_q;
  assign stop_p     = stop_q;
  assign scl_rise_p = rise_q;
  assign scl_fall_p = fall_q;

endmodule // i2c_cond_detect

// ---- tb/i2c_port_status_checker.sv ----
// port-level assertions for the two-wire port status register
// assumes it is bound to i2c_port_status and sees only its ports
module i2c_port_status_checker (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic [4:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [3:0]  byteenable,
  input wire logic        waitrequest,
  input wire logic [31:0] readdata,
  input wire logic        scl_pin,
  input wire logic        sda_pin,
  input wire logic        irq,
  input wire logic        slew_control_off,
  input wire logic        bus_level_select,
  input wire logic        master_active
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // completed status read and status low-lane write
  logic st_rd;
  logic st_wr;
  assign st_rd = !waitrequest && read && address == 5'h00;
  assign st_wr = !waitrequest && write && address == 5'h00 && byteenable[0];
  // request, then exactly one wait cycle
  sequence req_s; (read || write) && waitrequest; endsequence
  sequence done_s; !waitrequest ##1 waitrequest; endsequence
  a_access_one_wait: assert property (req_s |=> done_s)
    else $error("access not answered after one wait cycle");
  a_ack_needs_req: assert property (!waitrequest |-> (read || write))
    else $error("completion without a request");
  a_upper_zero: assert property (
    st_rd |-> readdata[31:8] == 24'h00_0000)
    else $error("upper status bits not zero");
  a_select_readback: assert property (
    st_rd |-> readdata[7:6] == {slew_control_off, bus_level_select})
    else $error("select outputs differ from status bits");
  a_slew_follows: assert property (
    st_wr |-> ##2 slew_control_off == $past(writedata[7], 2))
    else $error("slew select did not follow write");
  a_smbus_follows: assert property (
    st_wr |-> ##2 bus_level_select == $past(writedata[6], 2))
    else $error("smbus select did not follow write");
  a_cond_exclusive: assert property (
    st_rd |-> !(readdata[4] && readdata[3]))
    else $error("start and stop shown together");
  a_gen_active: assert property (
    !waitrequest && write && address == 5'h04 && byteenable[0]
      && writedata[7:3] != 5'h00 |-> ##[1:3] master_active)
    else $error("generator bit did not make master active");
  a_reset_idle: assert property (
    $fell(rst) |-> waitrequest && !irq && !slew_control_off)
    else $error("outputs not idle after reset");
  a_unmapped_zero: assert property (
    !waitrequest && read && address > 5'h18 |-> readdata == 32'h0000_0000)
    else $error("unmapped read not zero");
endmodule // i2c_port_status_checker

bind i2c_port_status i2c_port_status_checker i2c_port_status_checker_i (
  .clock(clock), .rst(rst), .address(address), .read(read),
  .write(write), .writedata(writedata), .byteenable(byteenable),
  .waitrequest(waitrequest), .readdata(readdata), .scl_pin(scl_pin),
  .sda_pin(sda_pin), .irq(irq), .slew_control_off(slew_control_off),
  .bus_level_select(bus_level_select), .master_active(master_active)
);

// ---- tb/i2c_bus_model.sv ----
// behavioural two-wire bus master clocking frames past the port
// assumes pull-ups: lines idle high, scl stands still between frames
module i2c_bus_model (
  output logic scl,
  output logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // one pulse of the 48 ns link clock
  task automatic pulse();
    #12 scl = 1'b1;
    #24 scl = 1'b0;
    #12;
  endtask
  // start or repeated start: sda falls while scl high
  task automatic start_c();
    sda = 1'b1;
    #12 scl = 1'b1;
    #12 sda = 1'b0;
    #12 scl = 1'b0;
    #24;
  endtask
  // eight bits msb first, then the ack clock with sda released
  task automatic byte_w(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      sda = b[i];
      pulse();
    end
    sda = 1'b1;
    pulse();
    #24;
  endtask
  // stop: sda rises while scl high
  task automatic stop_c();
    sda = 1'b0;
    #12 scl = 1'b1;
    #12 sda = 1'b1;
    #24;
  endtask
endmodule // i2c_bus_model

// ---- tb/i2c_port_status_tb_top.sv ----
// self-checking bench: avalon register accesses plus bus frames
// assumes the design, its checker and the bus model are compiled
module i2c_port_status_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [4:0] ST = i2c_status_pkg::OFF_STATUS;
  localparam logic [4:0] CT = i2c_status_pkg::OFF_CONTROL;
  localparam logic [4:0] OA = i2c_status_pkg::OFF_OWN_ADDR;
  localparam logic [4:0] DT = i2c_status_pkg::OFF_DATA;
  localparam logic [4:0] IS = i2c_status_pkg::OFF_IRQ_STATUS;
  localparam logic [4:0] IM = i2c_status_pkg::OFF_IRQ_MASK;
  logic        clock = 1'b0;
  logic        rst, read, write, waitrequest, irq, scl_pin, sda_pin;
  logic        slew_control_off, bus_level_select, master_active;
  logic [4:0]  address;
  logic [3:0]  byteenable;
  logic [31:0] writedata, readdata, rd_v;
  int          n_errors, samples_checked;
  always #2.5 clock = ~clock;
  i2c_port_status i2c_port_status_i (.clock(clock), .rst(rst),
    .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable),
    .waitrequest(waitrequest), .readdata(readdata), .scl_pin(scl_pin),
    .sda_pin(sda_pin), .irq(irq), .slew_control_off(slew_control_off),
    .bus_level_select(bus_level_select), .master_active(master_active));
  i2c_bus_model i2c_bus_model_i (.scl(scl_pin), .sda(sda_pin));
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one avalon access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [31:0] wd);
    @(posedge clock);
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= wd;
    // no cycle count assumed: only the watchdog ends a hung wait
    do begin
      @(posedge clock);
    end while (waitrequest !== 1'b0);
    rd_v = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input logic [4:0] a, input logic [31:0] e,
                     input logic [31:0] m = 32'hFFFF_FFFF);
    bus(1'b0, a, 32'h0000_0000);
    chk(rd_v & m, e);
  endtask
  // settle, then look at an output picked by index:
  // 0 slew select, 1 smbus select, 2 irq, 3 master active
  task automatic pin(input int s, input logic e);
    logic [3:0] o;
    repeat (3) @(posedge clock);
    o = {master_active, irq, bus_level_select, slew_control_off};
    chk({31'h0000_0000, o[s]}, {31'h0000_0000, e});
  endtask
  task automatic finish_test();
    $display("errors=%0d checks=%0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // watchdog against a hung handshake
  initial begin
    #100_000;
    n_errors++;
    finish_test();
  end
  initial begin
    rst = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = 5'h00;
    writedata = 32'h0000_0000;
    byteenable = 4'hF;
    n_errors = 0;
    samples_checked = 0;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    rdc(ST, 32'h0000_0000);
    rdc(IM, 32'h0000_0000);
    wr(ST, 32'hFFFF_FFFF);
    rdc(ST, 32'h0000_00C0);
    pin(0, 1'b1);
    pin(1, 1'b1);
    wr(ST, 32'h0000_0000);
    pin(0, 1'b0);
    pin(1, 1'b0);
    rdc(5'h1C, 32'h0000_0000);
    // slave, 7-bit address, all events unmasked
    wr(IM, 32'h0000_000F);
    wr(OA, 32'h0000_002A);
    wr(CT, 32'h0000_0001);
    i2c_bus_model_i.start_c();
    rdc(ST, 32'h0000_0008);
    pin(2, 1'b1);
    i2c_bus_model_i.byte_w(8'h54);
    rdc(ST, 32'h0000_0008);
    i2c_bus_model_i.byte_w(8'hA5);
    rdc(ST, 32'h0000_0029);
    rdc(DT, 32'h0000_00A5, 32'h0000_00FF);
    rdc(ST, 32'h0000_0028);
    i2c_bus_model_i.stop_c();
    rdc(ST, 32'h0000_0030);
    rdc(IS, 32'h0000_000F);
    wr(IS, 32'h0000_000F);
    rdc(IS, 32'h0000_0000);
    pin(2, 1'b0);
    // read request from the bus master
    i2c_bus_model_i.start_c();
    i2c_bus_model_i.byte_w(8'h55);
    rdc(ST, 32'h0000_000C);
    i2c_bus_model_i.stop_c();
    wr(CT, 32'h0000_0000);
    rdc(ST, 32'h0000_0000, 32'h0000_0018);
    // master role: a queued byte means transmit in progress
    wr(CT, 32'h0000_0003);
    wr(DT, 32'h0000_005A);
    rdc(ST, 32'h0000_0005);
    pin(3, 1'b1);
    rdc(i2c_status_pkg::OFF_ACTIVITY, 32'h0000_0001);
    wr(CT, 32'h0000_0000);
    pin(3, 1'b0);
    for (int b = 3; b < 8; b++) begin
      wr(CT, 32'h0000_0003 | (32'h0000_0001 << b));
      pin(3, 1'b1);
      wr(CT, 32'h0000_0000);
      pin(3, 1'b0);
    end
    // ten-bit slave: matched high byte asks for an address rewrite
    wr(OA, 32'h0000_03A5);
    wr(CT, 32'h0000_0005);
    i2c_bus_model_i.start_c();
    i2c_bus_model_i.byte_w(8'hF6);
    rdc(ST, 32'h0000_0002, 32'h0000_0002);
    wr(OA, 32'h0000_03A5);
    rdc(ST, 32'h0000_0000, 32'h0000_0002);
    i2c_bus_model_i.stop_c();
    finish_test();
  end
endmodule // i2c_port_status_tb_top
